/* verilog/fthc_defines.svh */
/*
  timing counts and thresholds for the fall-through buffer host controller.
  assumes a 250 MHz system clock.
*/
`ifndef FTHC_DEFINES_SVH
`define FTHC_DEFINES_SVH
`define FTHC_CLK_PERIOD_NS 4
`define FTHC_CLEAR_WIDTH_NS 45
`define FTHC_CLEAR_TO_PUSH_NS 75
`define FTHC_STROBE_HIGH_NS 27
`define FTHC_STROBE_LOW_NS 25
`define FTHC_FALL_THROUGH_TIME_NS 750
`define FTHC_CYC(ns) (((ns) + `FTHC_CLK_PERIOD_NS - 1) / `FTHC_CLK_PERIOD_NS)
`define FTHC_CNT_W 10
`define FTHC_DEPTH 64
`define FTHC_ALMOST_EMPTY_MAX 8
`define FTHC_ALMOST_FULL_MIN 56
`define FTHC_HALF_MIN 32
`endif

/* verilog/fthc_pkg.sv */
/*
  types shared by the host controller files.
  assumes nothing of its surroundings.
*/
package fthc_pkg;
  typedef logic [4:0] fthc_word_t;
  typedef enum logic [1:0] {FTHC_CLEARING, FTHC_SETTLE, FTHC_RUN} fthc_init_t;
  typedef enum logic [1:0] {FTHC_IDLE, FTHC_HIGH, FTHC_LOW} fthc_strobe_t;
endpackage : fthc_pkg

/* verilog/fthc_stream_if.sv */
/*
  valid/ready word channel between the controller and its skid buffer.
  assumes a single clock.
*/
`timescale 1ns/10ps
interface fthc_stream_if;
  logic valid;
  logic ready;
  fthc_pkg::fthc_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fthc_stream_if

/* verilog/fthc_skid_buf.sv */
/*
  two-entry buffer with valid and ready on both sides.
  assumes the same clock and reset as its user.
*/
`timescale 1ns/10ps
module fthc_skid_buf (
  input wire logic clk,
  input wire logic rstn,
  fthc_stream_if.snk inp,
  fthc_stream_if.src outp
);
  fthc_pkg::fthc_word_t mem_r [2];
  logic rdIdx_r;
  logic wrIdx_r;
  logic [1:0] cnt_r;
  logic doPush;
  logic doPop;

  assign inp.ready = (cnt_r != 2'h2);
  assign outp.valid = (cnt_r != 2'h0);
  assign outp.data = mem_r[rdIdx_r];
  assign doPush = inp.valid && inp.ready;
  assign doPop = outp.valid && outp.ready;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_r[0] <= 5'h00;
      mem_r[1] <= 5'h00;
    end else if (doPush) begin
      mem_r[wrIdx_r] <= inp.data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrIdx_r <= 1'b0;
      rdIdx_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (doPush) wrIdx_r <= ~wrIdx_r;
      if (doPop) rdIdx_r <= ~rdIdx_r;
      cnt_r <= cnt_r + {1'b0, doPush} - {1'b0, doPop};
    end
  end
endmodule : fthc_skid_buf

/* verilog/fthc_host.sv */
/*
  host controller for an external 64-word asynchronous fall-through buffer:
  drives the clear, push and pop strobes, and streams words in and out.
  assumes the device pins are asynchronous to clk; all device outputs are
  synchronised by two flip-flops before use.
*/
// Function
// [R01] pulse clear after reset before use
// [R02] push only with space; hold data around edge
// [R03] device drops space on accepting push
// [R04] device falls words toward output
// [R05] device raises space at push fall
// [R06] device raises word-available at output
// [R07] pop rise drops word-available; data held
// [R08] pop fall advances next word
// [R09] empty pop leaves outputs invalid
// [R10] long low handshake means full/empty
// [R11] push without space is ignored
// [R12] pop without word-available ignored
// [R13] held push loads once space rises
// [R14] 64 words of 4 or 5 bits
// [R15] outputs change only at pop fall
// [R16] almost-empty boundary at 9 words
// [R17] almost-full boundary at 55 words
// [R18] half-full boundary at 31 words
// [R19] AND handshakes of parallel devices
// [R20] edge-level flag set/clear by pop/push
// [R21] midpoint flag set/clear by push/pop
// [R22] clear holds space low until release
// [R23] clear forces outputs and word-available low
// [R24] clear empties pointers and count
`timescale 1ns/10ps
`include "fthc_defines.svh"
module fthc_host (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrValid,
  output logic wrReady,
  input wire fthc_pkg::fthc_word_t wrData,
  output logic rdValid,
  input wire logic rdReady,
  output fthc_pkg::fthc_word_t rdData,
  input wire logic clearReq,
  output logic initDone,
  output logic devFull,
  output logic devEmpty,
  output logic [`FTHC_CNT_W-1:0] hostCount,
  output logic clear_n,
  output logic pushStrobe,
  output fthc_pkg::fthc_word_t pushData,
  input wire logic [1:0] spaceAvailIn,
  output logic popStrobe,
  input wire fthc_pkg::fthc_word_t popData,
  input wire logic [1:0] wordAvailIn,
  input wire logic edgeLevelFlagIn,
  input wire logic midpointFlagIn,
  output logic almostEmpty,
  output logic almostFull,
  output logic midpoint
);
  localparam int ClearCyc = `FTHC_CYC(`FTHC_CLEAR_WIDTH_NS);
  localparam int SettleCyc = `FTHC_CYC(`FTHC_CLEAR_TO_PUSH_NS);
  localparam int HighCyc = `FTHC_CYC(`FTHC_STROBE_HIGH_NS);
  localparam int LowCyc = `FTHC_CYC(`FTHC_STROBE_LOW_NS);
  localparam int FtCyc = `FTHC_CYC(`FTHC_FALL_THROUGH_TIME_NS);

  // each pin is synchronised on its own; ANDing raw pins first would pass a glitch into the flops
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  fthc_pkg::fthc_word_t dSync1_r;
  fthc_pkg::fthc_word_t dSync2_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      dSync1_r <= 5'h00;
      dSync2_r <= 5'h00;
    end else begin
      sync1_r <= {midpointFlagIn, edgeLevelFlagIn, wordAvailIn, spaceAvailIn};
      sync2_r <= sync1_r;
      dSync1_r <= popData;
      dSync2_r <= dSync1_r;
    end
  end
  logic spaceS;
  logic wordS;
  // two parallel devices widen the word; their handshakes are ANDed
  assign spaceS = &sync2_r[1:0]; // [R19]
  assign wordS = &sync2_r[3:2]; // [R19]
  assign almostEmpty = sync2_r[4] && (hostCount <= `FTHC_CNT_W'(`FTHC_ALMOST_EMPTY_MAX)); // [R16] [R20]
  assign almostFull = sync2_r[4] && (hostCount >= `FTHC_CNT_W'(`FTHC_ALMOST_FULL_MIN)); // [R17] [R20]
  assign midpoint = sync2_r[5]; // [R18] [R21]

  // init sequencer: clear pulse, then settle before first push
  fthc_pkg::fthc_init_t init_r;
  logic [`FTHC_CNT_W-1:0] initCnt_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_r <= fthc_pkg::FTHC_CLEARING;
      initCnt_r <= '0;
    end else begin
      case (init_r)
        fthc_pkg::FTHC_CLEARING: begin
          if (initCnt_r == `FTHC_CNT_W'(ClearCyc - 1)) begin
            init_r <= fthc_pkg::FTHC_SETTLE; // [R01]
            initCnt_r <= '0;
          end else begin
            initCnt_r <= initCnt_r + 1'b1;
          end
        end
        fthc_pkg::FTHC_SETTLE: begin
          if (initCnt_r == `FTHC_CNT_W'(SettleCyc - 1)) begin
            init_r <= fthc_pkg::FTHC_RUN;
            initCnt_r <= '0;
          end else begin
            initCnt_r <= initCnt_r + 1'b1;
          end
        end
        fthc_pkg::FTHC_RUN: begin
          if (clearReq && !pushStrobe && !popStrobe) begin
            init_r <= fthc_pkg::FTHC_CLEARING;
          end
        end
        default: init_r <= fthc_pkg::FTHC_CLEARING;
      endcase
    end
  end
  assign clear_n = (init_r != fthc_pkg::FTHC_CLEARING); // [R01] [R22] [R23] [R24]
  assign initDone = (init_r == fthc_pkg::FTHC_RUN);

  // push side: data goes onto the pins on the same clock edge as the rise and stays until after the fall
  fthc_pkg::fthc_strobe_t push_r;
  logic [`FTHC_CNT_W-1:0] pushCnt_r;
  logic pushSeenLow_r;
  assign wrReady = initDone && (push_r == fthc_pkg::FTHC_IDLE) && spaceS && !clearReq; // [R02] [R11]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      push_r <= fthc_pkg::FTHC_IDLE;
      pushCnt_r <= '0;
      pushStrobe <= 1'b0;
      pushData <= 5'h00;
      pushSeenLow_r <= 1'b0;
    end else begin
      case (push_r)
        fthc_pkg::FTHC_IDLE: begin
          if (wrValid && wrReady) begin
            pushData <= wrData; // [R02]
            pushStrobe <= 1'b1;
            push_r <= fthc_pkg::FTHC_HIGH;
            pushCnt_r <= '0;
            pushSeenLow_r <= 1'b0;
          end
        end
        fthc_pkg::FTHC_HIGH: begin
          // space must drop to confirm acceptance before the strobe falls
          if (!spaceS) pushSeenLow_r <= 1'b1; // [R03] [R13]
          if (pushCnt_r >= `FTHC_CNT_W'(HighCyc - 1) && (pushSeenLow_r || !spaceS)) begin
            pushStrobe <= 1'b0; // [R05]
            push_r <= fthc_pkg::FTHC_LOW;
            pushCnt_r <= '0;
          end else begin
            pushCnt_r <= pushCnt_r + 1'b1;
          end
        end
        fthc_pkg::FTHC_LOW: begin
          if (pushCnt_r >= `FTHC_CNT_W'(LowCyc + 2)) begin
            push_r <= fthc_pkg::FTHC_IDLE;
          end else begin
            pushCnt_r <= pushCnt_r + 1'b1;
          end
        end
        default: push_r <= fthc_pkg::FTHC_IDLE;
      endcase
    end
  end

  // pop side feeds the two-entry buffer through popWord_r; pops only when popWord_r is empty
  fthc_stream_if popStream ();
  fthc_stream_if outStream ();
  fthc_pkg::fthc_strobe_t pop_r;
  logic [`FTHC_CNT_W-1:0] popCnt_r;
  fthc_pkg::fthc_word_t popWord_r;
  logic popHave_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pop_r <= fthc_pkg::FTHC_IDLE;
      popCnt_r <= '0;
      popStrobe <= 1'b0;
      popWord_r <= 5'h00;
      popHave_r <= 1'b0;
    end else begin
      if (popHave_r && popStream.ready) popHave_r <= 1'b0;
      case (pop_r)
        fthc_pkg::FTHC_IDLE: begin
          // word-available low: no pop is issued at all
          if (initDone && wordS && !popHave_r && !clearReq) begin // [R06] [R12]
            popWord_r <= dSync2_r; // [R07]
            popStrobe <= 1'b1;
            pop_r <= fthc_pkg::FTHC_HIGH;
            popCnt_r <= '0;
          end
        end
        fthc_pkg::FTHC_HIGH: begin
          if (popCnt_r >= `FTHC_CNT_W'(HighCyc - 1) && !wordS) begin
            popStrobe <= 1'b0; // [R07] [R15]
            popHave_r <= 1'b1;
            pop_r <= fthc_pkg::FTHC_LOW;
            popCnt_r <= '0;
          end else begin
            popCnt_r <= popCnt_r + 1'b1;
          end
        end
        fthc_pkg::FTHC_LOW: begin
          // wait out sync delay so a stale word-available is not reused
          if (popCnt_r >= `FTHC_CNT_W'(LowCyc + 2)) begin // [R08] [R09]
            pop_r <= fthc_pkg::FTHC_IDLE;
          end else begin
            popCnt_r <= popCnt_r + 1'b1;
          end
        end
        default: pop_r <= fthc_pkg::FTHC_IDLE;
      endcase
    end
  end
  assign popStream.valid = popHave_r;
  assign popStream.data = popWord_r;

  fthc_skid_buf u_buf (
    .clk(clk),
    .rstn(rstn),
    .inp(popStream.snk),
    .outp(outStream.src)
  );
  assign rdValid = outStream.valid;
  assign rdData = outStream.data;
  assign outStream.ready = rdReady;

  // occupancy tracking and full/empty from long-low handshakes
  logic pushDone;
  logic popDone;
  assign pushDone = (push_r == fthc_pkg::FTHC_HIGH) && (pushCnt_r >= `FTHC_CNT_W'(HighCyc - 1))
                    && (pushSeenLow_r || !spaceS);
  assign popDone = (pop_r == fthc_pkg::FTHC_HIGH) && (popCnt_r >= `FTHC_CNT_W'(HighCyc - 1)) && !wordS;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hostCount <= '0;
    end else if (!clear_n) begin
      hostCount <= '0; // [R24]
    end else if (hostCount <= `FTHC_CNT_W'(`FTHC_DEPTH)) begin // [R14]
      hostCount <= hostCount + {{(`FTHC_CNT_W-1){1'b0}}, pushDone} - {{(`FTHC_CNT_W-1){1'b0}}, popDone};
    end
  end

  logic [`FTHC_CNT_W-1:0] spLow_r;
  logic [`FTHC_CNT_W-1:0] wdLow_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spLow_r <= '0;
      wdLow_r <= '0;
      devFull <= 1'b0;
      devEmpty <= 1'b1;
    end else begin
      spLow_r <= (spaceS || !clear_n) ? '0 : ((spLow_r == `FTHC_CNT_W'(FtCyc)) ? spLow_r : spLow_r + 1'b1);
      wdLow_r <= wordS ? '0 : ((wdLow_r == `FTHC_CNT_W'(FtCyc)) ? wdLow_r : wdLow_r + 1'b1);
      devFull <= (spLow_r == `FTHC_CNT_W'(FtCyc)) && !spaceS; // [R10]
      devEmpty <= (wdLow_r == `FTHC_CNT_W'(FtCyc)) && !wordS; // [R10]
    end
  end
endmodule : fthc_host

/* testbench/fthc_host_chk.sv */
/* port checker for the buffer host controller.
   assumes it is bound into fthc_host with one clock. */
`timescale 1ns/10ps
`include "fthc_defines.svh"
module fthc_host_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire fthc_pkg::fthc_word_t wrData,
  input wire logic clearReq,
  input wire logic initDone,
  input wire logic [`FTHC_CNT_W-1:0] hostCount,
  input wire logic clear_n,
  input wire logic pushStrobe,
  input wire fthc_pkg::fthc_word_t pushData,
  input wire logic popStrobe,
  input wire logic [1:0] wordAvailIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_clear_before_use: assert property (!clear_n |-> !initDone && !wrReady) else $error("busy in clear");
  a_push_takes_word: assert property (wrValid && wrReady |=> $rose(pushStrobe) && pushData == $past(wrData))
    else $error("push not launched");
  a_push_data_held: assert property ($rose(pushStrobe) |=> (pushStrobe && $stable(pushData))[*6])
    else $error("push pulse short");
  a_push_low_gap: assert property ($fell(pushStrobe) |-> !pushStrobe[*8]) else $error("push gap short");
  a_pop_needs_word: assert property ($rose(popStrobe) |-> $past(&wordAvailIn, 2)) else $error("pop on empty");
  a_pop_high_min: assert property ($rose(popStrobe) |-> popStrobe[*7]) else $error("pop pulse short");
  a_clear_quiet: assert property (!clear_n |-> !pushStrobe && !popStrobe) else $error("strobe in clear");
  a_clear_zero_count: assert property (!clear_n ##1 !clear_n |-> hostCount == 0) else $error("count kept");
  a_clear_req_block: assert property (clearReq |-> !wrReady) else $error("write during clear");
  c_push: cover property ($rose(pushStrobe));
  c_pop: cover property ($rose(popStrobe));
  c_clear: cover property (clearReq && !clear_n);
endmodule : fthc_host_chk
bind fthc_host fthc_host_chk i_chk (.clk(clk), .rstn(rstn), .wrValid(wrValid), .wrReady(wrReady),
  .wrData(wrData), .clearReq(clearReq), .initDone(initDone), .hostCount(hostCount), .clear_n(clear_n),
  .pushStrobe(pushStrobe), .pushData(pushData), .popStrobe(popStrobe), .wordAvailIn(wordAvailIn));

/* testbench/fthc_dev_model.sv */
/* behavioural 64-word fall-through buffer device.
   assumes strobes from a clocked host; ftLim sets fall-through in 5 ns steps. */
`timescale 1ns/10ps
module fthc_dev_model (
  input wire logic clear_n,
  input wire logic pushStrobe,
  input wire fthc_pkg::fthc_word_t pushData,
  input wire logic popStrobe,
  output logic spaceAvail,
  output logic wordAvail,
  output fthc_pkg::fthc_word_t popData,
  output logic edgeLevelFlag,
  output logic midpointFlag
);
  fthc_pkg::fthc_word_t q[$];
  int ftLim = 2;
  int ftCnt = 0;
  logic popped = 0;
  initial begin
    spaceAvail = 0;
    wordAvail = 0;
    popData = 5'h00;
  end
  always @(posedge pushStrobe) if (spaceAvail && clear_n) begin
    q.push_back(pushData);
    #8 spaceAvail = 0;
  end
  always @(negedge pushStrobe) if (clear_n) #10 spaceAvail = (q.size() < 64);
  always @(posedge popStrobe) if (wordAvail) begin
    popped = 1;
    #8 wordAvail = 0;
  end
  always @(negedge popStrobe) if (popped) begin
    popped = 0;
    void'(q.pop_front());
    ftCnt = 0;
    // stale word is inverted so an idle bus never passes for data
    #5 popData = ~popData;
  end
  always #5 begin
    if (!clear_n || popStrobe || wordAvail || q.size() == 0) ftCnt = 0;
    else begin
      ftCnt++;
      if (ftCnt >= ftLim) begin
        popData = q[0];
        wordAvail = 1;
      end
    end
    edgeLevelFlag = q.size() <= 8 || q.size() >= 56;
    midpointFlag = q.size() >= 32;
  end
  always @(negedge clear_n) begin
    q.delete();
    popped = 0;
    #10 spaceAvail = 0;
    wordAvail = 0;
    popData = 5'h00;
  end
  always @(posedge clear_n) #10 spaceAvail = 1;
endmodule : fthc_dev_model

/* testbench/fthc_host_tb.sv */
/* self-checking bench: host controller against the device model.
   assumes the design, checker and model are compiled first. */
`timescale 1ns/10ps
`include "fthc_defines.svh"
module fthc_host_tb;
  logic clk = 0;
  logic rstn = 0;
  logic wrValid = 0;
  logic rdReady = 0;
  logic clearReq = 0;
  logic rdEn = 0;
  logic flush = 0;
  fthc_pkg::fthc_word_t wrData = 5'h00;
  logic wrReady, rdValid, initDone, devFull, devEmpty, clear_n, pushStrobe, popStrobe;
  logic almostEmpty, almostFull, midpoint, space, word, elFlag, mpFlag;
  fthc_pkg::fthc_word_t rdData, pushData, popData;
  logic [`FTHC_CNT_W-1:0] hostCount;
  fthc_pkg::fthc_word_t expQ[$];
  int seed = 34669;
  int bad_count = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  // one model drives both lanes, so the ANDed handshakes see one device
  fthc_host i_dut (.clk(clk), .rstn(rstn), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .clearReq(clearReq), .initDone(initDone),
    .devFull(devFull), .devEmpty(devEmpty), .hostCount(hostCount), .clear_n(clear_n),
    .pushStrobe(pushStrobe), .pushData(pushData), .spaceAvailIn({space, space}), .popStrobe(popStrobe),
    .popData(popData), .wordAvailIn({word, word}), .edgeLevelFlagIn(elFlag), .midpointFlagIn(mpFlag),
    .almostEmpty(almostEmpty), .almostFull(almostFull), .midpoint(midpoint));
  fthc_dev_model i_dev (.clear_n(clear_n), .pushStrobe(pushStrobe), .pushData(pushData),
    .popStrobe(popStrobe), .spaceAvail(space), .wordAvail(word), .popData(popData),
    .edgeLevelFlag(elFlag), .midpointFlag(mpFlag));
  function automatic logic [2:0] expFlags(input int n);
    return {n >= 32, n >= 56, n <= 8};
  endfunction : expFlags
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic push(input fthc_pkg::fthc_word_t w, output bit ok);
    int n;
    n = 0;
    ok = 0;
    @(negedge clk);
    wrValid = 1;
    wrData = w;
    while (wrReady !== 1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    // valid drops at once on a timeout, so a late ready cannot take an unrecorded word
    if (wrReady === 1) begin
      ok = 1;
      expQ.push_back(w);
      @(negedge clk);
    end
    wrValid = 0;
  endtask : push
  task automatic wait_init;
    int n;
    for (n = 0; n < 200 && initDone !== 1; n++) @(negedge clk);
    check(10'(initDone), 10'h001, "init done");
    check(10'(clear_n), 10'h001, "clear released");
    check(10'(hostCount), 10'h000, "count after clear");
    check(10'({midpoint, almostFull, almostEmpty}), 10'(expFlags(0)), "flags empty");
  endtask : wait_init
  task automatic drain;
    int n;
    rdEn = 1;
    for (n = 0; n < 8000 && expQ.size() != 0; n++) @(negedge clk);
    check(10'(expQ.size()), 10'h000, "words lost");
  endtask : drain
  always @(negedge clk) begin
    rdReady = rdEn && (($random(seed) & 3) != 0);
    if (rdValid === 1 && rdReady) begin
      if (flush) expQ.delete();
      else if (expQ.size() == 0) check(10'h001, 10'h000, "extra word");
      else check(10'(rdData), 10'(expQ.pop_front()), "read order");
    end
  end
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    bit ok;
    int n;
    repeat (3) @(negedge clk);
    rstn = 1;
    wait_init();
    $display("init test ended");
    for (int s = 0; s < 2; s++) begin
      i_dev.ftLim = s ? 150 : 2;
      push(5'h1F, ok);
      push(5'h00, ok);
      for (int i = 0; i < 12; i++) begin
        push(5'($random(seed)), ok);
        check(10'(ok), 10'h001, "push taken");
      end
      drain();
      $display("stream test %0d ended", s);
    end
    i_dev.ftLim = 2;
    rdEn = 0;
    for (n = 0; n < 80; n++) begin
      push(5'($random(seed)), ok);
      if (!ok) break;
    end
    check(10'(devFull), 10'h001, "full seen");
    check(10'(wrReady), 10'h000, "refused when full");
    check(10'(hostCount), 10'h040, "device count");
    check(10'(i_dev.q.size()), 10'h040, "device depth");
    check(10'({midpoint, almostFull, almostEmpty}), 10'(expFlags(64)), "flags full");
    $display("fill test ended");
    drain();
    repeat (250) @(negedge clk);
    check(10'(devEmpty), 10'h001, "empty seen");
    check(10'(hostCount), 10'h000, "count drained");
    check(10'({midpoint, almostFull, almostEmpty}), 10'(expFlags(0)), "flags drained");
    $display("drain test ended");
    rdEn = 0;
    for (n = 0; n < 5; n++) push(5'($random(seed)), ok);
    clearReq = 1;
    for (n = 0; n < 400 && clear_n !== 0; n++) @(negedge clk);
    // the device takes some ns to drop its handshake after clear falls
    repeat (3) @(negedge clk);
    check(10'(clear_n), 10'h000, "clear issued");
    check(10'(word), 10'h000, "word gone in clear");
    check(10'(popData), 10'h000, "data low in clear");
    clearReq = 0;
    wait_init();
    check(10'(i_dev.q.size()), 10'h000, "device emptied");
    check(10'(space), 10'h001, "space after clear");
    flush = 1;
    rdEn = 1;
    repeat (100) @(negedge clk);
    flush = 0;
    expQ.delete();
    for (n = 0; n < 3; n++) push(5'($random(seed)), ok);
    drain();
    $display("clear test ended");
    end_of_test();
  end
endmodule : fthc_host_tb
